/* File: shared/bscl_pkg.sv */
package bscl_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ        = 10_000_000;  // Oscillator logic clock
    localparam int SW_FREQ_HZ    = 1_600_000;   // Nominal switching rate
    localparam int SW_CYC        = CLK_HZ / SW_FREQ_HZ;  // Rounded down
    localparam int SLOW_DIV      = 3;           // Short-output slowdown
    localparam int SW_SLOW_CYC   = SW_CYC * SLOW_DIV;
    localparam int SKIP_ENTRY    = 8;           // Zero-cross cycles to skip
    localparam int REF_BIAS_US   = 600;         // Reference bias-up time
    localparam int REF_BIAS_CYC  = REF_BIAS_US * (CLK_HZ / 1_000_000);
    localparam int SS_TIME_US    = 1100;        // Soft start-up time
    localparam int SS_CYC        = SS_TIME_US * (CLK_HZ / 1_000_000);

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0]  CTRL_OFS       = 4'h0;
    localparam logic [3:0]  STATUS_OFS     = 4'h4;
    localparam int          CTRL_SKIP_BIT  = 0;  // Allow pulse skipping
    localparam int          CTRL_DROP_BIT  = 1;  // Allow 100% duty dropout
    localparam logic [31:0] CTRL_RST       = 32'h0000_0003;
    localparam int          ST_STATE_LSB   = 0;  // Three bits of state
    localparam int          ST_SKIP_BIT    = 4;
    localparam int          ST_IDLE_BIT    = 5;
    localparam int          ST_REFRDY_BIT  = 6;
    localparam int          ST_DROP_BIT    = 7;
    localparam int          ST_ZC_LSB      = 8;  // Four bits of zero-cross count

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic peak_trip;      // Current loop peak reached
        logic overcurrent;    // High-side current at limit
        logic zero_cross;     // Low-side current crossed zero
        logic skip_trip;      // Current at 20% of peak limit
        logic out_high;       // Output 1.5% above nominal
        logic out_at_nominal; // Output fallen back to nominal
        logic out_low;        // Output 1.5% below nominal
        logic short_fb;       // Feedback below 0.2V
        logic undervoltage;   // Input below lockout threshold
        logic thermal;        // Over-temperature
        logic dropout;        // Input too low to regulate
    } bscl_cmp_t;

    typedef struct packed {
        logic enable;
        logic keepalive;
        logic mode;
    } bscl_pins_t;

    typedef enum logic [2:0] {
        ST_OFF, ST_STANDBY, ST_REF_WAKE, ST_SOFTSTART, ST_RUN, ST_THERMAL
    } bscl_state_t;

endpackage : bscl_pkg

/* File: src/bscl_sync.sv */
`timescale 1ns/1ns
module bscl_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_srst,
    // Asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    // ------------------------------------------------------------------
    // Two-stage synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end
endmodule : bscl_sync

/* File: src/bscl_ctrl.sv */
`timescale 1ns/1ns
// Summary of operation
// - PWM: high-side switch turns on at every oscillator cycle start.
// - Peak trip: high-side off, low-side on until cycle end.
// - Mode high: count consecutive zero-cross cycles, enter skip at 8.
// - Outside skip, zero-cross count clears in any cycle without a crossing; in skip it holds at 8.
// - Skip pulses start on clock, end at 20% of peak limit.
// - Skip: output 1.5% high ends pulse, idle after current discharges.
// - Skip idle resumes clock-aligned pulses when output falls to nominal.
// - Output 1.5% below nominal returns from skip to fixed PWM.
// - Mode low: always fixed PWM, never pulse skipping.
// - Enable high wakes reference first, then soft start-up.
// - Enable low: high-side off, regulation stops, discharge path on.
// - Undervoltage keeps regulator disabled with both switches off.
// - Overcurrent ends high-side conduction immediately.
// - Feedback below 0.2V runs oscillator at one third frequency.
// - Input too low outside skip: high-side held on continuously, 100% duty.
// - Over-temperature shuts down; restart through soft start-up.
// - Keepalive pin powers reference; ready after 600us bias-up.
// - Enable low with keepalive high gives standby, reference on.
module bscl_ctrl #(
    parameter int REF_BIAS_CYC = bscl_pkg::REF_BIAS_CYC,
    parameter int SS_CYC       = bscl_pkg::SS_CYC
) (
    // Clock and reset
    input  wire logic              i_ref_clk,
    input  wire logic              i_srst,
    // Host pins and analog comparator flags
    input  wire bscl_pkg::bscl_pins_t i_pins,
    input  wire bscl_pkg::bscl_cmp_t  i_cmp,
    // Avalon-MM slave
    input  wire logic [3:0]        i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    output logic      [31:0]       o_avs_readdata,
    output logic                   o_avs_waitrequest,
    // Power stage and analog control
    output logic                   o_hs_gate,
    output logic                   o_ls_gate,
    output logic                   o_ref_on,
    output logic                   o_discharge,
    output logic                   o_softstart,
    output logic                   o_skip_mode
);
    // ------------------------------------------------------------------
    // Synchronised inputs
    // ------------------------------------------------------------------
    bscl_pkg::bscl_pins_t pins_s;
    bscl_pkg::bscl_cmp_t  cmp_s;

    // Pins and flags pass two flops before any logic
    bscl_sync #(.WIDTH($bits(bscl_pkg::bscl_pins_t))) u_pin_sync (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_async   (i_pins),
        .o_sync    (pins_s)
    );
    bscl_sync #(.WIDTH($bits(bscl_pkg::bscl_cmp_t))) u_cmp_sync (
        .i_ref_clk (i_ref_clk),
        .i_srst    (i_srst),
        .i_async   (i_cmp),
        .o_sync    (cmp_s)
    );

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    bscl_pkg::bscl_state_t state;
    bscl_pkg::bscl_state_t next_state;
    bscl_pkg::bscl_state_t idle_state;
    logic [31:0] ctrl;
    logic [15:0] ref_cnt;
    logic [15:0] ss_cnt;
    logic [4:0]  phase;
    logic [3:0]  zc_cnt;
    logic        hs_on;
    logic        ls_on;
    logic        zc_seen;
    logic        skip_active;
    logic        skip_idle;
    logic        acc_done;

    function automatic logic [4:0] period_of(input logic slow);
        period_of = slow ? 5'(bscl_pkg::SW_SLOW_CYC) : 5'(bscl_pkg::SW_CYC);
    endfunction : period_of

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire ref_pwr    = (pins_s.keepalive | pins_s.enable) & ~cmp_s.undervoltage;
    wire ref_ready  = (ref_cnt == 16'(REF_BIAS_CYC));
    wire ss_done    = (ss_cnt == 16'(SS_CYC));
    wire switching  = (state == bscl_pkg::ST_SOFTSTART) | (state == bscl_pkg::ST_RUN);
    wire cyc_start  = switching & (phase == 5'h00);
    wire cyc_end    = switching & (phase == period_of(cmp_s.short_fb) - 5'h01);
    wire skip_allow = pins_s.mode & ctrl[bscl_pkg::CTRL_SKIP_BIT]
                      & (state == bscl_pkg::ST_RUN);
    wire dropout    = cmp_s.dropout & ctrl[bscl_pkg::CTRL_DROP_BIT] & ~skip_active;
    wire zc_now     = zc_seen | (ls_on & cmp_s.zero_cross);
    wire skip_leave = skip_active & (cmp_s.out_low | ~skip_allow);
    // Normal end of a high-side pulse: peak in PWM, 20% or output high in skip
    wire hs_term    = hs_on & (skip_active ? (cmp_s.skip_trip | cmp_s.out_high)
                                           : (cmp_s.peak_trip & ~dropout));
    wire hs_kill    = cmp_s.overcurrent | ~switching | ~pins_s.enable
                      | cmp_s.undervoltage;
    wire acc_req    = i_avs_read | i_avs_write;
    wire [31:0] status_word = {20'h0_0000, zc_cnt, dropout, ref_ready, skip_idle,
                               skip_active, 1'b0, state};
    wire [31:0] rd_mux = (i_avs_address == bscl_pkg::CTRL_OFS)   ? ctrl :
                         (i_avs_address == bscl_pkg::STATUS_OFS) ? status_word :
                         32'h0000_0000;

    // ------------------------------------------------------------------
    // Sequencing state machine
    // ------------------------------------------------------------------
    assign idle_state = pins_s.keepalive ? bscl_pkg::ST_STANDBY : bscl_pkg::ST_OFF;

    // Enable, standby, protection and restart ordering
    always_comb begin
        next_state = state;
        case (state)
            bscl_pkg::ST_OFF: begin
                if (pins_s.enable) begin
                    next_state = bscl_pkg::ST_REF_WAKE;
                end else if (pins_s.keepalive) begin
                    next_state = bscl_pkg::ST_STANDBY;
                end
            end
            bscl_pkg::ST_STANDBY: begin
                if (pins_s.enable) begin
                    next_state = bscl_pkg::ST_REF_WAKE;
                end else if (!pins_s.keepalive) begin
                    next_state = bscl_pkg::ST_OFF;
                end
            end
            bscl_pkg::ST_REF_WAKE: begin
                if (!pins_s.enable) begin
                    next_state = idle_state;
                end else if (cmp_s.thermal) begin
                    next_state = bscl_pkg::ST_THERMAL;
                end else if (ref_ready) begin
                    next_state = bscl_pkg::ST_SOFTSTART;
                end
            end
            bscl_pkg::ST_SOFTSTART, bscl_pkg::ST_RUN: begin
                if (!pins_s.enable) begin
                    next_state = idle_state;
                end else if (cmp_s.thermal) begin
                    next_state = bscl_pkg::ST_THERMAL;
                end else if (state == bscl_pkg::ST_SOFTSTART && ss_done) begin
                    next_state = bscl_pkg::ST_RUN;
                end
            end
            bscl_pkg::ST_THERMAL: begin
                if (!pins_s.enable) begin
                    next_state = idle_state;
                end else if (!cmp_s.thermal) begin
                    next_state = bscl_pkg::ST_REF_WAKE;
                end
            end
            default: next_state = bscl_pkg::ST_OFF;
        endcase
        if (cmp_s.undervoltage) begin
            next_state = bscl_pkg::ST_OFF;
        end
    end

    // State register
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state <= bscl_pkg::ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // Reference bias-up and soft start timers
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst || !ref_pwr) begin
            ref_cnt <= 16'h0000;
        end else if (!ref_ready) begin
            ref_cnt <= ref_cnt + 16'h0001;
        end
        if (i_srst || state != bscl_pkg::ST_SOFTSTART) begin
            ss_cnt <= 16'h0000;
        end else if (!ss_done) begin
            ss_cnt <= ss_cnt + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // Switching oscillator
    // ------------------------------------------------------------------
    // Phase counter; period triples while feedback is low
    always_ff @(posedge i_ref_clk) begin
        if (i_srst || !switching || cyc_end) begin
            phase <= 5'h00;
        end else begin
            phase <= phase + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // Pulse-skipping control
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            zc_cnt      <= 4'h0;
            skip_active <= 1'b0;
            skip_idle   <= 1'b0;
            zc_seen     <= 1'b0;
        end else begin
            // Crossing seen this cycle; a crossing at the end still counts
            zc_seen <= cyc_end ? 1'b0 : zc_now;
            if (skip_leave) begin
                skip_active <= 1'b0;
                skip_idle   <= 1'b0;
                zc_cnt      <= 4'h0;
            end else if (!skip_active && !skip_allow) begin
                zc_cnt <= 4'h0;
            end else if (!skip_active && cyc_end) begin
                if (!zc_now) begin
                    zc_cnt <= 4'h0;
                end else if (zc_cnt == 4'(bscl_pkg::SKIP_ENTRY - 1)) begin
                    zc_cnt      <= 4'(bscl_pkg::SKIP_ENTRY);
                    skip_active <= 1'b1;
                end else begin
                    zc_cnt <= zc_cnt + 4'h1;
                end
            end else if (skip_active) begin
                if (cmp_s.out_high) begin
                    skip_idle <= 1'b1;
                end else if (cmp_s.out_at_nominal) begin
                    skip_idle <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Switch requests
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst || hs_kill) begin
            hs_on <= 1'b0;
        end else if (hs_term) begin
            hs_on <= 1'b0;
        end else if (cyc_start && !(skip_active && skip_idle)) begin
            hs_on <= 1'b1;
        end
        if (i_srst || !switching || cmp_s.undervoltage) begin
            ls_on <= 1'b0;
        end else if (hs_on && (hs_term || cmp_s.overcurrent)) begin
            ls_on <= 1'b1;
        end else if (skip_active ? cmp_s.zero_cross : cyc_end) begin
            ls_on <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Gate drive with break-before-make
    // ------------------------------------------------------------------
    // A gate turns on only after the other was off for a full cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_hs_gate   <= 1'b0;
            o_ls_gate   <= 1'b0;
            o_ref_on    <= 1'b0;
            o_discharge <= 1'b1;
            o_softstart <= 1'b0;
            o_skip_mode <= 1'b0;
        end else begin
            o_hs_gate   <= hs_on & ~o_ls_gate;
            o_ls_gate   <= ls_on & ~hs_on & ~o_hs_gate;
            o_ref_on    <= ref_pwr;
            o_discharge <= ~pins_s.enable | cmp_s.undervoltage;
            o_softstart <= (state == bscl_pkg::ST_SOFTSTART);
            o_skip_mode <= skip_active;
        end
    end

    // ------------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, then completion
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ctrl              <= bscl_pkg::CTRL_RST;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0000_0000;
            acc_done          <= 1'b0;
        end else begin
            acc_done          <= acc_req & o_avs_waitrequest;
            o_avs_waitrequest <= ~(acc_req & o_avs_waitrequest);
            if (acc_req && o_avs_waitrequest) begin
                o_avs_readdata <= rd_mux;
            end
            if (i_avs_write && acc_done &&
                i_avs_address == bscl_pkg::CTRL_OFS) begin
                ctrl <= {30'h0000_0000, i_avs_writedata[1:0]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    AST_NO_OVERLAP:
    assert property (!(o_hs_gate && o_ls_gate)) else $error("both gates on");
    AST_BBM_GAP:
    assert property ($rose(o_hs_gate) |-> !$past(o_ls_gate)) else $error("no dead time");
    AST_PWM_START:
    assert property (cyc_start && !skip_active && !hs_kill && !hs_term |=> hs_on ##1 o_hs_gate)
        else $error("no pulse at cycle start");
    AST_PEAK_SWAP:
    assert property (hs_on && !skip_active && cmp_s.peak_trip && !dropout && !hs_kill
                     |=> !hs_on && ls_on) else $error("peak trip ignored");
    AST_OCP_CUT:
    assert property (cmp_s.overcurrent |=> !hs_on ##1 !o_hs_gate)
        else $error("overcurrent not cut");
    AST_SKIP_ENTRY:
    assert property ($rose(skip_active) |-> zc_cnt == 4'(bscl_pkg::SKIP_ENTRY) && $past(pins_s.mode))
        else $error("skip entered without eight crossings");
    AST_ZC_CLEAR:
    assert property (cyc_end && !skip_active && !zc_now |=> zc_cnt == 4'h0)
        else $error("zero-cross count kept");
    AST_FORCED_PWM:
    assert property (!pins_s.mode |=> !skip_active) else $error("skip in forced PWM");
    AST_INPUT_UNDERVOLTAGE_LOCKOUT_OFF:
    assert property (cmp_s.undervoltage |=> state == bscl_pkg::ST_OFF ##1 !o_hs_gate && !o_ls_gate)
        else $error("lockout not honoured");
    AST_EN_LOW:
    assert property (!pins_s.enable |=> !hs_on && o_discharge) else $error("disable failed");
    AST_SLOW_OSC:
    assert property (cmp_s.short_fb && switching && phase < 5'(bscl_pkg::SW_SLOW_CYC - 1)
                     |=> phase != 5'h00 || !$past(cmp_s.short_fb))
        else $error("oscillator not slowed");
    AST_BUS_ACK:
    assert property (acc_req && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("bus answer late");

    COV_SKIP:    cover property ($rose(skip_active));
    COV_IDLE:    cover property (skip_active && skip_idle ##[1:40] !skip_idle);
    COV_THERMAL: cover property (state == bscl_pkg::ST_THERMAL ##[1:40] state == bscl_pkg::ST_REF_WAKE);
    COV_DROPOUT: cover property (dropout && o_hs_gate [*8]);
endmodule : bscl_ctrl

/* File: sim/bscl_host_model.sv */
`timescale 1ns/1ns
module bscl_host_model #(
    parameter int LEAD = 30,
    parameter int HOLD = 30
) (
    // Clock and bench requests
    input  wire logic           i_ref_clk,
    input  wire logic           i_want_en,
    input  wire logic           i_want_keep,
    input  wire logic           i_want_mode,
    // Host pins
    output bscl_pkg::bscl_pins_t o_pins
);
    int keep_cnt = 0;
    int on_cnt   = 0;
    initial o_pins = '0;
    // Pins move after the edge; enable waits for keepalive lead
    always @(posedge i_ref_clk) begin
        keep_cnt         <= o_pins.keepalive ? keep_cnt + 1 : 0;
        on_cnt           <= (o_pins.enable && o_pins.keepalive) ? on_cnt + 1 : 0;
        o_pins.keepalive <= i_want_keep;
        o_pins.mode      <= i_want_mode;
        if (i_want_en && ((!i_want_keep && !o_pins.keepalive) || keep_cnt >= LEAD)) begin
            o_pins.enable <= 1'b1;
        end else if (!i_want_en && (!i_want_keep || on_cnt >= HOLD)) begin
            o_pins.enable <= 1'b0;
        end
    end
endmodule : bscl_host_model

/* File: sim/buck_switch_control_logic_tb_top.sv */
`timescale 1ns/1ns
module buck_switch_control_logic_tb_top;
    logic clk, srst, w_en, w_keep, w_mode, rd, wr, wreq, hs, ls, ref_on, dis, ss, skip;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, q, seed;
    bscl_pkg::bscl_cmp_t  cmp;
    bscl_pkg::bscl_pins_t pins;
    int fail_count = 0;
    int total_checks = 0;
    int n, p;
    bscl_host_model host (.i_ref_clk(clk), .i_want_en(w_en), .i_want_keep(w_keep),
        .i_want_mode(w_mode), .o_pins(pins));
    bscl_ctrl #(.REF_BIAS_CYC(20), .SS_CYC(30)) dut (.i_ref_clk(clk), .i_srst(srst),
        .i_pins(pins), .i_cmp(cmp), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .o_hs_gate(hs), .o_ls_gate(ls), .o_ref_on(ref_on),
        .o_discharge(dis), .o_softstart(ss), .o_skip_mode(skip));
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #2_000_000;
        fail_count++;
        close_out();
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function logic pick(input int s);
        case (s)
            0: return hs;
            1: return ls;
            2: return skip;
            3: return ss;
            default: return dis;
        endcase
    endfunction : pick
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task wt(input int s, input logic v, input int lim, output int c);
        c = 0;
        while (pick(s) !== v && c < lim) begin
            @(negedge clk);
            c++;
        end
        chk("wait_output", {31'h0, v}, {31'h0, pick(s)});
    endtask : wt
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int c;
        c = 0;
        @(posedge clk);
        rd <= !w; wr <= w; addr <= a; wdata <= d;
        do begin
            @(posedge clk);
            c++;
        end while (wreq !== 1'b0 && c < 50);
        q = rdata;
        rd <= 1'b0; wr <= 1'b0;
        chk("bus_answer", 32'h0000_0000, {31'h0, wreq});
    endtask : bus
    task wst(input logic [2:0] v);
        int c;
        c = 0;
        do begin
            bus(1'b0, bscl_pkg::STATUS_OFS, 32'h0000_0000);
            c++;
        end while (q[2:0] !== v && c < 80);
        chk("state", {29'h0, v}, {29'h0, q[2:0]});
    endtask : wst
    task per(output int pd);
        int c;
        wt(0, 1'b0, 60, c);
        wt(0, 1'b1, 60, c);
        wt(0, 1'b0, 60, pd);
        wt(0, 1'b1, 60, c);
        pd = pd + c;
    endtask : per
    task close_out();
        if (fail_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    // Gates never both on
    always @(negedge clk) if (!srst) chk("gate_overlap", 32'h0000_0000, {31'h0, hs & ls});
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {srst, w_en, w_keep, w_mode, rd, wr} = 6'b100_000;
        addr = 4'h0; wdata = 32'h0000_0000; cmp = '0; seed = 32'h0000_7c6f;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk("reset_outs", 32'h0000_0001, {ss, skip, ref_on, hs, ls, dis});
        bus(1'b0, bscl_pkg::CTRL_OFS, 32'h0000_0000);
        chk("ctrl_reset", bscl_pkg::CTRL_RST, q);
        seed = lfsr(seed);
        bus(1'b1, bscl_pkg::CTRL_OFS, seed);
        bus(1'b0, bscl_pkg::CTRL_OFS, 32'h0000_0000);
        chk("ctrl_rw", seed & 32'h0000_0003, q);
        bus(1'b1, 4'h8, 32'hffff_ffff);
        bus(1'b0, 4'h8, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, q);
        bus(1'b1, bscl_pkg::STATUS_OFS, 32'hffff_ffff);
        bus(1'b1, bscl_pkg::CTRL_OFS, 32'h0000_0003);
        wst(3'd0);
        w_keep <= 1'b1; w_en <= 1'b1;
        wt(3, 1'b1, 200, n);
        chk("ref_first", 32'h0000_0001, {31'h0, ref_on});
        wst(3'd4);
        @(posedge clk) cmp.peak_trip <= 1'b1;
        per(p);
        chk("pwm_period", 32'd6, p);
        wt(1, 1'b1, 8, n);
        @(posedge clk) cmp.short_fb <= 1'b1;
        repeat (40) @(negedge clk);
        per(p);
        chk("slow_period", 32'd18, p);
        @(posedge clk) {cmp.short_fb, cmp.dropout} <= 2'b01;
        repeat (12) @(negedge clk);
        n = 0;
        repeat (12) @(negedge clk) n += hs;
        chk("dropout_hold", 32'd12, n);
        @(posedge clk) cmp.overcurrent <= 1'b1;
        wt(0, 1'b0, 5, n);
        @(posedge clk) {cmp.overcurrent, cmp.dropout, cmp.zero_cross} <= 3'b001;
        repeat (120) @(negedge clk);
        chk("forced_pwm", 32'h0000_0000, {31'h0, skip});
        @(posedge clk) w_mode <= 1'b1;
        repeat (36) @(negedge clk);
        @(posedge clk) cmp.zero_cross <= 1'b0;
        repeat (12) @(negedge clk);
        @(posedge clk) cmp.zero_cross <= 1'b1;
        wt(2, 1'b1, 70, n);
        chk("skip_count", 32'h0000_0001, {31'h0, n >= 42});
        @(posedge clk) {cmp.peak_trip, cmp.skip_trip} <= 2'b01;
        per(p);
        chk("skip_period", 32'd6, p);
        @(posedge clk) cmp.out_high <= 1'b1;
        wt(0, 1'b0, 5, n);
        repeat (5) @(negedge clk);
        n = 0;
        repeat (12) @(negedge clk) n += hs;
        chk("skip_hold", 32'd0, n);
        bus(1'b0, bscl_pkg::STATUS_OFS, 32'h0000_0000);
        chk("skip_idle", 32'h0000_0001, {31'h0, q[bscl_pkg::ST_IDLE_BIT]});
        @(posedge clk) {cmp.out_high, cmp.out_at_nominal} <= 2'b01;
        wt(0, 1'b1, 12, n);
        @(posedge clk) cmp.out_low <= 1'b1;
        wt(2, 1'b0, 10, n);
        @(posedge clk) w_en <= 1'b0;
        wt(5, 1'b1, 50, n);
        @(negedge clk);
        chk("hs_off", 32'h0000_0000, {31'h0, hs});
        wst(3'd1);
        w_en <= 1'b1;
        wst(3'd4);
        @(posedge clk) cmp.undervoltage <= 1'b1;
        wt(0, 1'b0, 6, n);
        repeat (8) @(negedge clk);
        chk("uv_gates", 32'h0000_0000, {30'h0, hs, ls});
        @(posedge clk) {cmp.undervoltage, cmp.thermal} <= 2'b01;
        wst(3'd5);
        @(posedge clk) cmp.thermal <= 1'b0;
        wt(3, 1'b1, 200, n);
        repeat (300) begin
            seed = lfsr(seed);
            @(posedge clk) cmp <= seed[10:0];
        end
        close_out();
    end
endmodule : buck_switch_control_logic_tb_top
